// ---- pad_attribute_control.sv ----
// Pad attribute control for ports B and C with an AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Eight port B pull-enable bits, one per pin.
// - Pull forced off on pins driven as output by port or peripheral.
// - Pull forced off on pins owned by an analog function.
// - Port B direction bit 0 selects pullup, 1 selects pulldown.
// - Selected pull device active only while pull-enable is set.
// - Eight port B slew bits; set enables slew limiting.
// - Slew setting ignored on pins configured as inputs.
// - Eight port B drive strength bits choose low or high drive.
// - Four port C pull-enable bits, one per pin.
// - Four port C pull-direction bits: 1 pulldown, 0 pullup.
// - Four port C slew bits; set turns slew limiting on.
// - Pull, slew and drive registers never alter pin data or direction.
// - Set port C direction bit enables driver and counts as output.
module pad_attribute_control (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [pad_attr_pkg::ADDR_WIDTH-1:0] s_axil_awaddr,
	input wire logic [2:0] s_axil_awprot,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [pad_attr_pkg::DATA_WIDTH-1:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [pad_attr_pkg::ADDR_WIDTH-1:0] s_axil_araddr,
	input wire logic [2:0] s_axil_arprot,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [pad_attr_pkg::DATA_WIDTH-1:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	input wire logic [pad_attr_pkg::PORT_B_PINS-1:0] port_b_output_enable,
	input wire logic [pad_attr_pkg::PORT_B_PINS-1:0] port_b_peripheral_output,
	input wire logic [pad_attr_pkg::PORT_B_PINS-1:0] port_b_analog_select,
	input wire logic [pad_attr_pkg::PORT_C_PINS-1:0] port_c_peripheral_output,
	input wire logic [pad_attr_pkg::PORT_C_PINS-1:0] port_c_analog_select,
	output logic [pad_attr_pkg::PORT_B_PINS-1:0] port_b_pullup,
	output logic [pad_attr_pkg::PORT_B_PINS-1:0] port_b_pulldown,
	output logic [pad_attr_pkg::PORT_B_PINS-1:0] port_b_slew,
	output logic [pad_attr_pkg::PORT_B_PINS-1:0] port_b_high_drive,
	output logic [pad_attr_pkg::PORT_C_PINS-1:0] port_c_pullup,
	output logic [pad_attr_pkg::PORT_C_PINS-1:0] port_c_pulldown,
	output logic [pad_attr_pkg::PORT_C_PINS-1:0] port_c_slew,
	output logic [pad_attr_pkg::PORT_C_PINS-1:0] port_c_output_driver
);
	import pad_attr_pkg::*;

	localparam int BP = PORT_B_PINS;
	localparam int CP = PORT_C_PINS;

	logic [ADDR_WIDTH-1:0] write_addr;
	logic [DATA_WIDTH-1:0] write_data;
	logic [3:0] write_strb;
	logic have_addr;
	logic have_data;
	logic write_fire;
	logic write_hit;
	logic read_hit;
	logic [DATA_WIDTH-1:0] read_value;
	logic [BP-1:0] b_pull_enable;
	logic [BP-1:0] b_pull_direction;
	logic [BP-1:0] b_slew_enable;
	logic [BP-1:0] b_drive_strength;
	logic [CP-1:0] c_pull_enable;
	logic [CP-1:0] c_pull_direction;
	logic [CP-1:0] c_slew_enable;
	logic [CP-1:0] c_direction;
	logic [BP-1:0] b_output_active;
	logic [CP-1:0] c_output_active;
	logic [BP-1:0] next_b_pullup;
	logic [BP-1:0] next_b_pulldown;
	logic [BP-1:0] next_b_slew;
	logic [CP-1:0] next_c_pullup;
	logic [CP-1:0] next_c_pulldown;
	logic [CP-1:0] next_c_slew;
	logic wr_b_pe;
	logic wr_b_pd;
	logic wr_b_se;
	logic wr_b_ds;
	logic wr_c_pe;
	logic wr_c_pd;
	logic wr_c_se;
	logic wr_c_dir;

	// Write address channel: accept once, hold until the write fires
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			have_addr <= 1'b0;
			write_addr <= '0;
		end
		else if (s_axil_awvalid && s_axil_awready)
		begin
			have_addr <= 1'b1;
			write_addr <= s_axil_awaddr;
		end
		else if (write_fire)
			have_addr <= 1'b0;
	end

	// Write data channel: independent of address arrival order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			have_data <= 1'b0;
			write_data <= '0;
			write_strb <= '0;
		end
		else if (s_axil_wvalid && s_axil_wready)
		begin
			have_data <= 1'b1;
			write_data <= s_axil_wdata;
			write_strb <= s_axil_wstrb;
		end
		else if (write_fire)
			have_data <= 1'b0;
	end

	// Ready only while the slot is empty and no response is pending
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axil_awready <= 1'b0;
			s_axil_wready <= 1'b0;
		end
		else
		begin
			s_axil_awready <= !have_addr && !(s_axil_awvalid && s_axil_awready) && !s_axil_bvalid;
			s_axil_wready <= !have_data && !(s_axil_wvalid && s_axil_wready) && !s_axil_bvalid;
		end
	end

	assign write_fire = have_addr && have_data && !s_axil_bvalid;

	// Address decode for writes
	always_comb
	begin
		unique case (write_addr)
			OFFSET_B_PULL_ENABLE, OFFSET_B_PULL_DIRECTION, OFFSET_B_SLEW_ENABLE, OFFSET_B_DRIVE_STRENGTH,
			OFFSET_C_PULL_ENABLE, OFFSET_C_PULL_DIRECTION, OFFSET_C_SLEW_ENABLE, OFFSET_C_DIRECTION:
				write_hit = 1'b1;
			default:
				write_hit = 1'b0;
		endcase
	end

	// Write response: OKAY for mapped words, SLVERR otherwise
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axil_bvalid <= 1'b0;
			s_axil_bresp <= RESP_OKAY;
		end
		else if (write_fire)
		begin
			s_axil_bvalid <= 1'b1;
			s_axil_bresp <= write_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axil_bready)
			s_axil_bvalid <= 1'b0;
	end

	// Only byte lane 0 carries register data; port C keeps its low nibble
	always_comb
	begin
		wr_b_pe = 1'b0;
		wr_b_pd = 1'b0;
		wr_b_se = 1'b0;
		wr_b_ds = 1'b0;
		wr_c_pe = 1'b0;
		wr_c_pd = 1'b0;
		wr_c_se = 1'b0;
		wr_c_dir = 1'b0;
		if (write_fire && write_strb[0])
		begin
			unique case (write_addr)
				OFFSET_B_PULL_ENABLE: wr_b_pe = 1'b1;
				OFFSET_B_PULL_DIRECTION: wr_b_pd = 1'b1;
				OFFSET_B_SLEW_ENABLE: wr_b_se = 1'b1;
				OFFSET_B_DRIVE_STRENGTH: wr_b_ds = 1'b1;
				OFFSET_C_PULL_ENABLE: wr_c_pe = 1'b1;
				OFFSET_C_PULL_DIRECTION: wr_c_pd = 1'b1;
				OFFSET_C_SLEW_ENABLE: wr_c_se = 1'b1;
				OFFSET_C_DIRECTION: wr_c_dir = 1'b1;
				default: ; // Unmapped word, nothing is written
			endcase
		end
	end

	// Port B attribute registers
	pad_attr_reg #(.WIDTH(BP)) u_b_pull_enable (
		.aclk(aclk),
		.aresetn(aresetn),
		.write_enable(wr_b_pe),
		.write_data(write_data[BP-1:0]),
		.value(b_pull_enable)
	);
	pad_attr_reg #(.WIDTH(BP)) u_b_pull_direction (
		.aclk(aclk),
		.aresetn(aresetn),
		.write_enable(wr_b_pd),
		.write_data(write_data[BP-1:0]),
		.value(b_pull_direction)
	);
	pad_attr_reg #(.WIDTH(BP)) u_b_slew_enable (
		.aclk(aclk),
		.aresetn(aresetn),
		.write_enable(wr_b_se),
		.write_data(write_data[BP-1:0]),
		.value(b_slew_enable)
	);
	pad_attr_reg #(.WIDTH(BP)) u_b_drive_strength (
		.aclk(aclk),
		.aresetn(aresetn),
		.write_enable(wr_b_ds),
		.write_data(write_data[BP-1:0]),
		.value(b_drive_strength)
	);

	// Port C attribute registers, upper bits not stored
	pad_attr_reg #(.WIDTH(CP)) u_c_pull_enable (
		.aclk(aclk),
		.aresetn(aresetn),
		.write_enable(wr_c_pe),
		.write_data(write_data[CP-1:0]),
		.value(c_pull_enable)
	);
	pad_attr_reg #(.WIDTH(CP)) u_c_pull_direction (
		.aclk(aclk),
		.aresetn(aresetn),
		.write_enable(wr_c_pd),
		.write_data(write_data[CP-1:0]),
		.value(c_pull_direction)
	);
	pad_attr_reg #(.WIDTH(CP)) u_c_slew_enable (
		.aclk(aclk),
		.aresetn(aresetn),
		.write_enable(wr_c_se),
		.write_data(write_data[CP-1:0]),
		.value(c_slew_enable)
	);
	pad_attr_reg #(.WIDTH(CP)) u_c_direction (
		.aclk(aclk),
		.aresetn(aresetn),
		.write_enable(wr_c_dir),
		.write_data(write_data[CP-1:0]),
		.value(c_direction)
	);

	// A pin counts as output when the port or a shared peripheral drives it
	assign b_output_active = port_b_output_enable | port_b_peripheral_output;
	assign c_output_active = c_direction | port_c_peripheral_output;

	// Pull and slew resolution per port
	pad_pull_gate #(.PINS(BP)) u_b_gate (
		.pull_enable(b_pull_enable),
		.pull_direction(b_pull_direction),
		.slew_enable(b_slew_enable),
		.output_active(b_output_active),
		.analog_active(port_b_analog_select),
		.next_pullup(next_b_pullup),
		.next_pulldown(next_b_pulldown),
		.next_slew(next_b_slew)
	);
	pad_pull_gate #(.PINS(CP)) u_c_gate (
		.pull_enable(c_pull_enable),
		.pull_direction(c_pull_direction),
		.slew_enable(c_slew_enable),
		.output_active(c_output_active),
		.analog_active(port_c_analog_select),
		.next_pullup(next_c_pullup),
		.next_pulldown(next_c_pulldown),
		.next_slew(next_c_slew)
	);

	// Registered pad controls; pin data untouched, the port C direction register drives port_c_output_driver
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			port_b_pullup <= '0;
			port_b_pulldown <= '0;
			port_b_slew <= '0;
			port_b_high_drive <= '0;
			port_c_pullup <= '0;
			port_c_pulldown <= '0;
			port_c_slew <= '0;
			port_c_output_driver <= '0;
		end
		else
		begin
			port_b_pullup <= next_b_pullup;
			port_b_pulldown <= next_b_pulldown;
			port_b_slew <= next_b_slew;
			port_b_high_drive <= b_drive_strength;
			port_c_pullup <= next_c_pullup;
			port_c_pulldown <= next_c_pulldown;
			port_c_slew <= next_c_slew;
			port_c_output_driver <= c_direction;
		end
	end

	// Read data mux; unused upper bits read as zero
	always_comb
	begin
		read_value = '0;
		read_hit = 1'b1;
		unique case (s_axil_araddr)
			OFFSET_B_PULL_ENABLE: read_value[BP-1:0] = b_pull_enable;
			OFFSET_B_PULL_DIRECTION: read_value[BP-1:0] = b_pull_direction;
			OFFSET_B_SLEW_ENABLE: read_value[BP-1:0] = b_slew_enable;
			OFFSET_B_DRIVE_STRENGTH: read_value[BP-1:0] = b_drive_strength;
			OFFSET_C_PULL_ENABLE: read_value[CP-1:0] = c_pull_enable;
			OFFSET_C_PULL_DIRECTION: read_value[CP-1:0] = c_pull_direction;
			OFFSET_C_SLEW_ENABLE: read_value[CP-1:0] = c_slew_enable;
			OFFSET_C_DIRECTION: read_value[CP-1:0] = c_direction;
			default: read_hit = 1'b0;
		endcase
	end

	// Read channel: arready while idle, data one cycle after the address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axil_arready <= 1'b0;
			s_axil_rvalid <= 1'b0;
			s_axil_rdata <= '0;
			s_axil_rresp <= RESP_OKAY;
		end
		else if (s_axil_arvalid && s_axil_arready)
		begin
			s_axil_arready <= 1'b0;
			s_axil_rvalid <= 1'b1;
			s_axil_rdata <= read_value;
			s_axil_rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axil_rvalid)
		begin
			if (s_axil_rready)
			begin
				s_axil_rvalid <= 1'b0;
				s_axil_arready <= 1'b1;
			end
		end
		else
			s_axil_arready <= 1'b1;
	end
endmodule : pad_attribute_control
`default_nettype wire

// ---- pad_attr_pkg.sv ----
// Package with register map, widths and reset values for the pad attribute block
package pad_attr_pkg;
	localparam int ADDR_WIDTH = 6;
	localparam int DATA_WIDTH = 32;
	localparam int PORT_B_PINS = 8;
	localparam int PORT_C_PINS = 4;
	localparam logic [ADDR_WIDTH-1:0] OFFSET_B_PULL_ENABLE = 6'h00;
	localparam logic [ADDR_WIDTH-1:0] OFFSET_B_PULL_DIRECTION = 6'h04;
	localparam logic [ADDR_WIDTH-1:0] OFFSET_B_SLEW_ENABLE = 6'h08;
	localparam logic [ADDR_WIDTH-1:0] OFFSET_B_DRIVE_STRENGTH = 6'h0c;
	localparam logic [ADDR_WIDTH-1:0] OFFSET_C_PULL_ENABLE = 6'h10;
	localparam logic [ADDR_WIDTH-1:0] OFFSET_C_PULL_DIRECTION = 6'h14;
	localparam logic [ADDR_WIDTH-1:0] OFFSET_C_SLEW_ENABLE = 6'h18;
	localparam logic [ADDR_WIDTH-1:0] OFFSET_C_DIRECTION = 6'h1c;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic PULL_SELECT_UP = 1'b0;
endpackage : pad_attr_pkg

// ---- pad_attr_reg.sv ----
// One pad attribute register of WIDTH bits with write strobe and reset
`timescale 1ns/1ps
`default_nettype none
module pad_attr_reg #(
	parameter int WIDTH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic write_enable,
	input wire logic [WIDTH-1:0] write_data,
	output logic [WIDTH-1:0] value
);
	import pad_attr_pkg::*;

	// Register clears on reset and loads on a strobed write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			value <= RESET_VALUE[WIDTH-1:0];
		else if (write_enable)
			value <= write_data;
	end
endmodule : pad_attr_reg
`default_nettype wire

// ---- pad_pull_gate.sv ----
// Per-pin pull gating and slew qualification for one port
`timescale 1ns/1ps
`default_nettype none
module pad_pull_gate #(
	parameter int PINS = 8
) (
	input wire logic [PINS-1:0] pull_enable,
	input wire logic [PINS-1:0] pull_direction,
	input wire logic [PINS-1:0] slew_enable,
	input wire logic [PINS-1:0] output_active,
	input wire logic [PINS-1:0] analog_active,
	output logic [PINS-1:0] next_pullup,
	output logic [PINS-1:0] next_pulldown,
	output logic [PINS-1:0] next_slew
);
	import pad_attr_pkg::*;

	// Each pin resolves its own pull and slew controls
	for (genvar i = 0; i < PINS; i++)
	begin : g_pin
		logic pull_allowed;
		assign pull_allowed = pull_enable[i] & ~output_active[i] & ~analog_active[i];
		assign next_pullup[i] = pull_allowed & (pull_direction[i] == PULL_SELECT_UP);
		assign next_pulldown[i] = pull_allowed & (pull_direction[i] != PULL_SELECT_UP);
		assign next_slew[i] = slew_enable[i] & output_active[i];
	end
endmodule : pad_pull_gate
`default_nettype wire

// ---- pad_attr_chk.sv ----
// Port checker for the pad attribute block
`timescale 1ns/1ps
`default_nettype none
module pad_attr_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axil_awvalid,
	input wire logic s_axil_awready,
	input wire logic s_axil_wvalid,
	input wire logic s_axil_wready,
	input wire logic s_axil_bvalid,
	input wire logic [pad_attr_pkg::ADDR_WIDTH-1:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	input wire logic s_axil_arready,
	input wire logic [pad_attr_pkg::DATA_WIDTH-1:0] s_axil_rdata,
	input wire logic [1:0] s_axil_rresp,
	input wire logic s_axil_rvalid,
	input wire logic [7:0] port_b_output_enable,
	input wire logic [7:0] port_b_peripheral_output,
	input wire logic [7:0] port_b_analog_select,
	input wire logic [3:0] port_c_peripheral_output,
	input wire logic [3:0] port_c_analog_select,
	input wire logic [7:0] port_b_pullup,
	input wire logic [7:0] port_b_pulldown,
	input wire logic [7:0] port_b_slew,
	input wire logic [3:0] port_c_pullup,
	input wire logic [3:0] port_c_pulldown,
	input wire logic [3:0] port_c_slew,
	input wire logic [3:0] port_c_output_driver
);
	import pad_attr_pkg::*;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Address and data taken together, and a read address taken
	sequence wr_take;
		s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
	endsequence
	sequence rd_take;
		s_axil_arvalid && s_axil_arready;
	endsequence
	// Bus timing and read data shape
	a_write_resp_time: assert property (wr_take |-> ##2 s_axil_bvalid)
		else $error("write response late");
	a_read_upper_zero: assert property (rd_take |=> s_axil_rvalid && s_axil_rdata[31:8] == 24'h0)
		else $error("read answer late or upper bits set");
	a_unmapped_read: assert property (rd_take and s_axil_araddr[5] |=> s_axil_rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
	// Pull and slew gating against the previous cycle's pin ownership, and pullup and pulldown never both on
	a_b_output_pull: assert property ((($past(port_b_output_enable | port_b_peripheral_output)) & (port_b_pullup | port_b_pulldown)) == 8'h0)
		else $error("port b pull on an output pin");
	a_b_analog_pull: assert property (($past(port_b_analog_select) & (port_b_pullup | port_b_pulldown)) == 8'h0)
		else $error("port b pull on an analog pin");
	a_pull_one_way: assert property ((port_b_pullup & port_b_pulldown) == 8'h0 && (port_c_pullup & port_c_pulldown) == 4'h0)
		else $error("pullup and pulldown both on");
	a_b_slew_input: assert property ((port_b_slew & ~$past(port_b_output_enable | port_b_peripheral_output)) == 8'h0)
		else $error("port b slew on an input pin");
	a_c_driver_pull: assert property (((port_c_pullup | port_c_pulldown) & (port_c_output_driver | $past(port_c_peripheral_output | port_c_analog_select))) == 4'h0)
		else $error("port c pull on an owned pin");
	a_c_slew_input: assert property ((port_c_slew & ~(port_c_output_driver | $past(port_c_peripheral_output))) == 4'h0)
		else $error("port c slew on an input pin");
endmodule : pad_attr_chk
bind pad_attribute_control pad_attr_chk chk (.*);
`default_nettype wire

// ---- pad_cell_model.sv ----
// Behavioural pad cells: pin level from the pull devices
`timescale 1ns/1ps
`default_nettype none
module pad_cell_model #(
	parameter int PINS = 8
) (
	input wire logic clk,
	input wire logic [PINS-1:0] up_enable,
	input wire logic [PINS-1:0] down_enable,
	output logic [PINS-1:0] level
);
	logic drift = 1'b0;
	// An unpulled pin wanders every cycle so no level is implied
	always @(posedge clk)
		drift <= !drift;
	assign level = up_enable | (~down_enable & {PINS{drift}});
endmodule : pad_cell_model
`default_nettype wire

// ---- test_pad_attribute_control.sv ----
// Self-checking testbench for the pad attribute block
`timescale 1ns/1ps
`default_nettype none
module test_pad_attribute_control;
	import pad_attr_pkg::*;
	logic aclk, aresetn, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid, s_axil_bready;
	logic s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
	logic [5:0] s_axil_awaddr, s_axil_araddr;
	logic [2:0] s_axil_awprot, s_axil_arprot;
	logic [31:0] s_axil_wdata, s_axil_rdata, d;
	logic [3:0] s_axil_wstrb, port_c_peripheral_output, port_c_analog_select, port_c_pullup, port_c_pulldown;
	logic [3:0] port_c_slew, port_c_output_driver, c_level;
	logic [1:0] s_axil_bresp, s_axil_rresp, r;
	logic [7:0] port_b_output_enable, port_b_peripheral_output, port_b_analog_select, port_b_pullup;
	logic [7:0] port_b_pulldown, port_b_slew, port_b_high_drive, b_level;
	int failures = 0;
	int n_tests = 0;
	pad_attribute_control dut (.*);
	pad_cell_model #(.PINS(8)) pad_b (.clk(aclk), .up_enable(port_b_pullup), .down_enable(port_b_pulldown), .level(b_level));
	pad_cell_model #(.PINS(4)) pad_c (.clk(aclk), .up_enable(port_c_pullup), .down_enable(port_c_pulldown), .level(c_level));
	// Clock
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic end_of_test;
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic settle;
		repeat (3) @(posedge aclk);
	endtask : settle
	// Register write; each channel released when taken
	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		int n;
		@(posedge aclk);
		s_axil_awaddr <= a;
		s_axil_wdata <= v;
		s_axil_awvalid <= 1'b1;
		s_axil_wvalid <= 1'b1;
		s_axil_bready <= 1'b1;
		for (n = 0; n < 64; n++)
		begin
			@(posedge aclk);
			if (s_axil_awvalid && s_axil_awready) s_axil_awvalid <= 1'b0;
			if (s_axil_wvalid && s_axil_wready) s_axil_wvalid <= 1'b0;
			if (s_axil_bvalid) break;
		end
		s_axil_bready <= 1'b0;
		r = s_axil_bresp;
		if (n == 64)
		begin
			failures++;
			end_of_test();
		end
	endtask : wr
	// Register read
	task automatic rd(input logic [5:0] a);
		int n;
		@(posedge aclk);
		s_axil_araddr <= a;
		s_axil_arvalid <= 1'b1;
		s_axil_rready <= 1'b1;
		for (n = 0; n < 64; n++)
		begin
			@(posedge aclk);
			if (s_axil_arvalid && s_axil_arready) s_axil_arvalid <= 1'b0;
			if (s_axil_rvalid) break;
		end
		s_axil_rready <= 1'b0;
		d = s_axil_rdata;
		r = s_axil_rresp;
		if (n == 64)
		begin
			failures++;
			end_of_test();
		end
	endtask : rd
	// Every register reads back its own width only
	task automatic regs_scenario;
		for (int i = 0; i < 8; i++)
		begin
			rd(6'(i * 4));
			check(d, 32'h0);
			wr(6'(i * 4), 32'hffffff5a);
			check(r, RESP_OKAY);
			rd(6'(i * 4));
			check(d, (i < 4) ? 32'h5a : 32'ha);
		end
		wr(6'h20, 32'hff);
		check(r, RESP_SLVERR);
		rd(6'h24);
		check(r, RESP_SLVERR);
		check(d, 32'h0);
	endtask : regs_scenario
	// Port B pull select, gating by output and analog ownership
	task automatic b_pull_scenario;
		wr(OFFSET_B_PULL_ENABLE, 32'hff);
		wr(OFFSET_B_PULL_DIRECTION, 32'h0f);
		settle();
		check({port_b_pullup, port_b_pulldown, b_level}, 24'hf00ff0);
		port_b_output_enable <= 8'h01;
		port_b_peripheral_output <= 8'h02;
		port_b_analog_select <= 8'h04;
		settle();
		check({port_b_pullup, port_b_pulldown}, 16'hf008);
		wr(OFFSET_B_PULL_ENABLE, 32'h0);
		settle();
		check({port_b_pullup, port_b_pulldown}, 16'h0);
	endtask : b_pull_scenario
	// Port B slew only on outputs, drive strength copied
	task automatic b_slew_scenario;
		port_b_output_enable <= 8'h0;
		port_b_peripheral_output <= 8'h0;
		wr(OFFSET_B_SLEW_ENABLE, 32'hff);
		wr(OFFSET_B_DRIVE_STRENGTH, 32'ha5);
		settle();
		check({port_b_slew, port_b_high_drive}, 16'h00a5);
		port_b_output_enable <= 8'hf0;
		port_b_peripheral_output <= 8'h01;
		settle();
		check(port_b_slew, 8'hf1);
	endtask : b_slew_scenario
	// Port C pulls, direction driver and slew
	task automatic c_scenario;
		port_c_peripheral_output <= 4'h2;
		port_c_analog_select <= 4'h8;
		wr(OFFSET_C_PULL_ENABLE, 32'hf);
		wr(OFFSET_C_PULL_DIRECTION, 32'h3);
		wr(OFFSET_C_DIRECTION, 32'h1);
		wr(OFFSET_C_SLEW_ENABLE, 32'hf);
		settle();
		check({port_c_output_driver, port_c_pullup, port_c_pulldown}, 12'h140);
		check(port_c_slew, 4'h3);
		wr(OFFSET_C_PULL_DIRECTION, 32'hf);
		settle();
		check({port_c_pullup, port_c_pulldown, c_level[2]}, 9'h008);
		wr(OFFSET_B_PULL_ENABLE, 32'hff);
		settle();
		check(port_c_output_driver, 4'h1);
	endtask : c_scenario
	// Mid-run reset clears every pad control and the port C direction register
	task automatic reset_scenario;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check({port_b_pullup, port_b_pulldown, port_b_slew, port_b_high_drive}, 32'h0);
		check({port_c_pullup, port_c_pulldown, port_c_slew, port_c_output_driver}, 16'h0);
		rd(OFFSET_C_DIRECTION);
		check(d, 32'h0);
	endtask : reset_scenario
	// Main sequence
	initial
	begin
		aresetn = 1'b0;
		{s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = 5'h0;
		{s_axil_awaddr, s_axil_araddr, s_axil_awprot, s_axil_arprot} = 18'h0;
		s_axil_wdata = 32'h0;
		s_axil_wstrb = 4'hf;
		{port_b_output_enable, port_b_peripheral_output, port_b_analog_select} = 24'h0;
		{port_c_peripheral_output, port_c_analog_select} = 8'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		regs_scenario();
		b_pull_scenario();
		b_slew_scenario();
		c_scenario();
		reset_scenario();
		end_of_test();
	end
endmodule : test_pad_attribute_control
`default_nettype wire
